// [src/pfc_pkg.sv]
// Purpose: shared constants and types for the program fetch cache
// Assumes: 32-bit byte addresses, 256-bit lines and fetch packets
// Notes:   register offsets are byte addresses on the AHB-Lite port
package pfc_pkg;
    // register map
    localparam logic [31:0] REG_INV_START = 32'h2000_0000;
    localparam logic [31:0] REG_INV_CTRL  = 32'h2000_0004;
    localparam logic [31:0] RST_INV_START = 32'h0000_0000;
    localparam logic [15:0] RST_INV_CNT   = 16'h0000;
    localparam int          CNT_W         = 16;
    // line geometry: 256-bit line, eight 32-bit words
    localparam int LINE_BITS  = 256;
    localparam int LINE_OFS_W = 5;
    localparam int LINE_WORDS = 8;
    // mode field codes
    localparam logic [2:0] MODE_RST = 3'h0;
    localparam logic [2:0] MODE_ENA = 3'h2;
    localparam logic [2:0] MODE_FRZ = 3'h3;
    localparam logic [2:0] MODE_BYP = 3'h4;
    // memory pages: two rom pages, one ram page, external
    localparam logic [1:0] PG_ROM0 = 2'h0;
    localparam logic [1:0] PG_ROM1 = 2'h1;
    localparam logic [1:0] PG_RAM  = 2'h2;
    localparam logic [1:0] PG_EXT  = 2'h3;
    localparam logic [3:0] RAM_REGION = 4'h1;
    localparam logic [3:0] ROM_REGION = 4'h0;
    localparam int         ROM_PG_BIT = 18;
    localparam int         RAM_BANK_LO = 2;
    localparam int         ROM_BANK_LO = 3;
    // ahb
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    typedef struct packed {
        logic        vld;
        logic [31:0] addr;
    } pfc_acc_s;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_GWAIT,
        ST_IFILL,
        ST_XFILL,
        ST_INV
    } pfc_state_e;
endpackage

// [src/pfc_cache.sv]
// Purpose: direct-mapped program fetch cache with invalidate registers
// Assumes: internal memory answers a read one cycle after imem_rd
// Notes:   hits answer in one cycle; internal misses in three unless same-page data holds the fill back
`timescale 1ns/100ps
module pfc_cache #(
    parameter int CACHE_BYTES = 32768
) (
    input  wire logic                   sys_clk,
    input  wire logic                   arst_n,
    input  wire logic [2:0]             fetch_cache_mode_field,
    input  wire logic                   fetch_req,
    input  wire logic [31:0]            fetch_addr,
    output logic                        fetch_ready,
    output logic                        fetch_valid,
    output logic [255:0]                fetch_data,
    output logic                        imem_rd,
    output logic [31:0]                 imem_addr,
    input  wire logic                   imem_rvalid,
    input  wire logic [255:0]           imem_rdata,
    output logic                        pmp_req,
    output logic [31:0]                 pmp_addr,
    input  wire logic                   pmp_ack,
    input  wire logic [255:0]           pmp_rdata,
    input  wire pfc_pkg::pfc_acc_s      dat0_acc,
    input  wire pfc_pkg::pfc_acc_s      dat1_acc,
    input  wire pfc_pkg::pfc_acc_s      per_acc,
    output logic [2:0]                  acc_gnt,
    input  wire logic                   hsel,
    input  wire logic [31:0]            haddr,
    input  wire logic [1:0]             htrans,
    input  wire logic                   hwrite,
    input  wire logic [2:0]             hsize,
    input  wire logic [31:0]            hwdata,
    input  wire logic                   hready,
    output logic                        hreadyout,
    output logic [31:0]                 hrdata,
    output logic                        hresp
);
    localparam int LINES = CACHE_BYTES / (pfc_pkg::LINE_BITS / 8);
    localparam int IDX_W = $clog2(LINES);
    localparam int TAG_W = 32 - pfc_pkg::LINE_OFS_W - IDX_W;

    ////////////////////////////////////////////////////////////////////
    // address decode helpers

    function automatic logic [1:0] page_of(input logic [31:0] a);
        if (a[31:28] == pfc_pkg::RAM_REGION)
            page_of = pfc_pkg::PG_RAM;
        else if (a[31:28] == pfc_pkg::ROM_REGION)
            page_of = a[pfc_pkg::ROM_PG_BIT] ? pfc_pkg::PG_ROM1 : pfc_pkg::PG_ROM0;
        else
            page_of = pfc_pkg::PG_EXT;
    endfunction

    // rom banks are 64 bits wide, ram banks 32 bits
    function automatic logic [2:0] bank_of(input logic [31:0] a);
        if (page_of(a) == pfc_pkg::PG_RAM)
            bank_of = a[pfc_pkg::RAM_BANK_LO +: 3];
        else
            bank_of = {1'b0, a[pfc_pkg::ROM_BANK_LO +: 2]};
    endfunction
    function automatic logic same_bank(input logic [31:0] a, input logic [31:0] b);
        same_bank = (page_of(a) == page_of(b)) && (bank_of(a) == bank_of(b));
    endfunction
    function automatic logic [IDX_W-1:0] idx_of(input logic [31:0] a);
        idx_of = a[pfc_pkg::LINE_OFS_W +: IDX_W];
    endfunction
    function automatic logic [TAG_W-1:0] tag_of(input logic [31:0] a);
        tag_of = a[31 -: TAG_W];
    endfunction

    ////////////////////////////////////////////////////////////////////
    // state

    pfc_pkg::pfc_state_e st_q, st_d;
    logic [LINES-1:0]                vld_q;
    logic [TAG_W-1:0]                tag_q [LINES];
    logic [pfc_pkg::LINE_BITS-1:0]   line_q [LINES];
    logic [31:0]                     req_addr_q;
    logic                            fill_en_q;
    logic [29:0]                     inv_start_q;
    logic [29:0]                     inv_addr_q;
    logic [pfc_pkg::CNT_W-1:0]       inv_cnt_q, inv_cnt_d;
    logic                            fetch_ready_q, fetch_valid_q;
    logic [255:0]                    fetch_data_q;
    logic                            imem_rd_q, pmp_req_q;
    logic [31:0]                     imem_addr_q, pmp_addr_q;
    logic [2:0]                      gnt_q, gnt_d;
    logic                            hreadyout_q, hresp_q;
    logic [31:0]                     hrdata_q;
    logic                            wr_pend_q;
    logic [31:0]                     wr_addr_q;

    logic        accept, hit, fill_ok, fill_go, pmp_go, done, line_wr, ctrl_wr;
    logic [31:0] cur_addr;
    logic [255:0] done_data;
    logic [3:0]  inv_step;
    logic        inv_match;

    assign accept   = fetch_req && fetch_ready_q;
    assign cur_addr = (st_q == pfc_pkg::ST_IDLE) ? fetch_addr : req_addr_q;
    // bypass never hits but leaves every line untouched
    assign hit = vld_q[idx_of(cur_addr)] && (tag_q[idx_of(cur_addr)] == tag_of(cur_addr))
               && (fetch_cache_mode_field != pfc_pkg::MODE_BYP);
    // a line fill loses only to data on its own page
    assign fill_ok = !(dat0_acc.vld && page_of(dat0_acc.addr) == page_of(cur_addr))
                  && !(dat1_acc.vld && page_of(dat1_acc.addr) == page_of(cur_addr));
    assign done_data = (st_q == pfc_pkg::ST_XFILL) ? pmp_rdata : imem_rdata;
    assign ctrl_wr   = wr_pend_q && (wr_addr_q == pfc_pkg::REG_INV_CTRL);
    // words left in the current line, so ranges need not be aligned
    assign inv_step  = 4'(pfc_pkg::LINE_WORDS) - {1'b0, inv_addr_q[2:0]};
    assign inv_match = vld_q[idx_of({inv_addr_q, 2'b00})]
                    && (tag_q[idx_of({inv_addr_q, 2'b00})] == tag_of({inv_addr_q, 2'b00}));

    ////////////////////////////////////////////////////////////////////
    // fetch sequencer

    always_comb begin
        st_d    = st_q;
        fill_go = 1'b0;
        pmp_go  = 1'b0;
        done    = 1'b0;
        line_wr = 1'b0;
        case (st_q)
            pfc_pkg::ST_IDLE: begin
                if (accept && !hit && page_of(fetch_addr) == pfc_pkg::PG_EXT) begin
                    pmp_go = 1'b1;
                    st_d   = pfc_pkg::ST_XFILL;
                end else if (accept && !hit && fill_ok) begin
                    fill_go = 1'b1;
                    st_d    = pfc_pkg::ST_IFILL;
                end else if (accept && !hit) begin
                    st_d = pfc_pkg::ST_GWAIT;
                end else if (!accept && inv_cnt_q != '0) begin
                    st_d = pfc_pkg::ST_INV;
                end
            end
            pfc_pkg::ST_GWAIT: begin
                if (fill_ok) begin
                    fill_go = 1'b1;
                    st_d    = pfc_pkg::ST_IFILL;
                end
            end
            pfc_pkg::ST_IFILL: begin
                if (imem_rvalid) begin
                    done    = 1'b1;
                    line_wr = fill_en_q;
                    st_d    = pfc_pkg::ST_IDLE;
                end
            end
            pfc_pkg::ST_XFILL: begin
                if (pmp_ack) begin
                    done    = 1'b1;
                    line_wr = fill_en_q;
                    st_d    = pfc_pkg::ST_IDLE;
                end
            end
            pfc_pkg::ST_INV: begin
                if (inv_cnt_d == '0)
                    st_d = pfc_pkg::ST_IDLE;
            end
            default: st_d = pfc_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q          <= pfc_pkg::ST_IDLE;
            fetch_ready_q <= 1'b0;
        end else begin
            st_q          <= st_d;
            fetch_ready_q <= (st_d == pfc_pkg::ST_IDLE) && (inv_cnt_d == '0);
        end
    end

    // fill enable is fixed when the fetch is taken
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            req_addr_q <= 32'h0000_0000;
            fill_en_q  <= 1'b0;
        end else if (accept) begin
            req_addr_q <= fetch_addr;
            // unsupported codes, 000b among them, act as enable
            fill_en_q  <= (fetch_cache_mode_field != pfc_pkg::MODE_FRZ)
                       && (fetch_cache_mode_field != pfc_pkg::MODE_BYP);
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            fetch_valid_q <= 1'b0;
            fetch_data_q  <= '0;
        end else begin
            fetch_valid_q <= (accept && hit) || done;
            if (accept && hit)
                fetch_data_q <= line_q[idx_of(fetch_addr)];
            else if (done)
                fetch_data_q <= done_data;
        end
    end

    // whole 256-bit line asked for in one read
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            imem_rd_q   <= 1'b0;
            imem_addr_q <= 32'h0000_0000;
            pmp_req_q   <= 1'b0;
            pmp_addr_q  <= 32'h0000_0000;
        end else begin
            imem_rd_q <= fill_go;
            if (fill_go)
                imem_addr_q <= {cur_addr[31:pfc_pkg::LINE_OFS_W], 5'h00};
            if (pmp_go)
                pmp_req_q <= 1'b1;
            else if (pmp_ack)
                pmp_req_q <= 1'b0;
            if (pmp_go)
                pmp_addr_q <= {fetch_addr[31:pfc_pkg::LINE_OFS_W], 5'h00};
        end
    end

    ////////////////////////////////////////////////////////////////////
    // line storage

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            vld_q <= '0;
        end else if (line_wr) begin
            vld_q[idx_of(req_addr_q)] <= 1'b1;
        end else if (st_q == pfc_pkg::ST_INV && inv_match) begin
            vld_q[idx_of({inv_addr_q, 2'b00})] <= 1'b0;
        end
    end

    // data and tags need no reset: valid bits guard them
    always_ff @(posedge sys_clk) begin
        if (line_wr) begin
            tag_q[idx_of(req_addr_q)]  <= tag_of(req_addr_q);
            line_q[idx_of(req_addr_q)] <= done_data;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // invalidate walker, one line per cycle

    always_comb begin
        inv_cnt_d = inv_cnt_q;
        if (st_q == pfc_pkg::ST_INV) begin
            if (inv_cnt_q <= pfc_pkg::CNT_W'(inv_step))
                inv_cnt_d = '0;
            else
                inv_cnt_d = inv_cnt_q - pfc_pkg::CNT_W'(inv_step);
        end
        if (ctrl_wr)
            inv_cnt_d = hwdata[pfc_pkg::CNT_W-1:0];
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            inv_cnt_q   <= pfc_pkg::RST_INV_CNT;
            inv_addr_q  <= '0;
            inv_start_q <= pfc_pkg::RST_INV_START[31:2];
        end else begin
            inv_cnt_q <= inv_cnt_d;
            if (wr_pend_q && wr_addr_q == pfc_pkg::REG_INV_START)
                inv_start_q <= hwdata[31:2];
            if (ctrl_wr)
                inv_addr_q <= inv_start_q;
            else if (st_q == pfc_pkg::ST_INV)
                inv_addr_q <= {inv_addr_q[29:3] + 27'h1, 3'h0};
        end
    end

    ////////////////////////////////////////////////////////////////////
    // bank arbitration for the internal memories

    always_comb begin
        gnt_d[0] = dat0_acc.vld;
        gnt_d[1] = dat1_acc.vld && !(dat0_acc.vld && same_bank(dat0_acc.addr, dat1_acc.addr));
        gnt_d[2] = per_acc.vld
                && !(gnt_d[0] && same_bank(per_acc.addr, dat0_acc.addr))
                && !(gnt_d[1] && same_bank(per_acc.addr, dat1_acc.addr))
                && !(fill_go && page_of(per_acc.addr) == page_of(cur_addr))
                && !(gnt_d[0] && gnt_d[1] && fill_go);
    end

    // grants are registered: a requester holds its request until granted
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n)
            gnt_q <= 3'h0;
        else
            gnt_q <= gnt_d;
    end

    ////////////////////////////////////////////////////////////////////
    // ahb-lite slave, zero wait states

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            hreadyout_q <= 1'b0;
            hresp_q     <= 1'b0;
            hrdata_q    <= 32'h0000_0000;
            wr_pend_q   <= 1'b0;
            wr_addr_q   <= 32'h0000_0000;
        end else begin
            hreadyout_q <= 1'b1;
            hresp_q     <= 1'b0;
            wr_pend_q   <= 1'b0;
            if (hsel && hready && htrans[1]) begin
                wr_pend_q <= hwrite;
                wr_addr_q <= haddr;
                if (!hwrite) begin
                    case (haddr)
                        pfc_pkg::REG_INV_START: hrdata_q <= {inv_start_q, 2'b00};
                        pfc_pkg::REG_INV_CTRL:  hrdata_q <= {16'h0000, inv_cnt_d};
                        default:                hrdata_q <= 32'h0000_0000;
                    endcase
                end
            end
        end
    end

    assign fetch_ready = fetch_ready_q;
    assign fetch_valid = fetch_valid_q;
    assign fetch_data  = fetch_data_q;
    assign imem_rd     = imem_rd_q;
    assign imem_addr   = imem_addr_q;
    assign pmp_req     = pmp_req_q;
    assign pmp_addr    = pmp_addr_q;
    assign acc_gnt     = gnt_q;
    assign hreadyout   = hreadyout_q;
    assign hrdata      = hrdata_q;
    assign hresp       = hresp_q;

    ////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    sequence s_ifill;
        imem_rd_q ##1 imem_rvalid;
    endsequence

    a_hit_one_cycle: assert property (accept && hit |=> fetch_valid_q)
        else $error("hit not answered next cycle");
    a_fill_penalty: assert property (s_ifill |=> fetch_valid_q && st_q == pfc_pkg::ST_IDLE)
        else $error("internal fill not answered after two cycles");
    a_miss_to_fill: assert property (accept && !hit && fill_ok
            && page_of(fetch_addr) != pfc_pkg::PG_EXT |=> imem_rd_q)
        else $error("internal miss did not issue a line read");
    a_enable_fill: assert property (accept && fetch_cache_mode_field == pfc_pkg::MODE_ENA |=> fill_en_q)
        else $error("enable mode would not fill");
    a_freeze_nofill: assert property (accept && fetch_cache_mode_field == pfc_pkg::MODE_FRZ
            |=> !fill_en_q)
        else $error("freeze mode would alter a line");
    a_bypass_miss: assert property (accept && fetch_cache_mode_field == pfc_pkg::MODE_BYP
            |=> !fetch_valid_q && !fill_en_q)
        else $error("bypass fetch treated as hit or filled");
    a_reset_mode: assert property (accept && fetch_cache_mode_field == pfc_pkg::MODE_RST |=> fill_en_q)
        else $error("reset mode code not treated as enable");
    a_ext_port: assert property (accept && !hit && page_of(fetch_addr) == pfc_pkg::PG_EXT
            |=> pmp_req_q && !imem_rd_q)
        else $error("external miss not sent to master port");
    a_inv_stall: assert property (inv_cnt_q != '0 |-> !fetch_ready_q)
        else $error("fetch accepted during invalidation");
    a_line_wr_valid: assert property (line_wr |=> vld_q[idx_of($past(req_addr_q))])
        else $error("filled line not marked valid");
    a_three_max: assert property ($countones({gnt_q, imem_rd_q}) <= 3)
        else $error("more than three parallel accesses");
    a_fill_page: assert property (imem_rd_q |-> !($past(dat0_acc.vld)
            && page_of($past(dat0_acc.addr)) == page_of(imem_addr_q)))
        else $error("line fill granted against same-page data");
    a_bank_par: assert property (dat0_acc.vld && dat1_acc.vld
            && page_of(dat0_acc.addr) != page_of(dat1_acc.addr) |=> gnt_q[1:0] == 2'h3)
        else $error("different-page data accesses stalled");
endmodule

// [verification/pfc_mem_model.sv]
// Purpose: far-side model: internal rom/ram line reads and external fill port
// Assumes: internal read answers one cycle after imem_rd; external fill after pmp_lat extra cycles
// Notes:   read data lines invert every cycle outside their valid cycle, so the last line shows again every other cycle
`timescale 1ns/100ps
module pfc_mem_model (
    input  wire logic         sys_clk,
    input  wire logic         arst_n,
    input  wire logic [31:0]  salt,
    input  wire logic [3:0]   pmp_lat,
    input  wire logic         imem_rd,
    input  wire logic [31:0]  imem_addr,
    output logic              imem_rvalid,
    output logic [255:0]      imem_rdata,
    input  wire logic         pmp_req,
    input  wire logic [31:0]  pmp_addr,
    output logic              pmp_ack,
    output logic [255:0]      pmp_rdata
);
    logic [3:0] wait_q;
    logic       fire;

    // word i of a line is its own byte address; ram words are salted so an overlay shows
    function automatic logic [255:0] line_of(input logic [31:0] a);
        for (int i = 0; i < 8; i++) begin
            line_of[i*32 +: 32] = {a[31:5], i[2:0], 2'h0} ^ ((a[31:28] == 4'h1) ? salt : 32'h0);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            imem_rvalid <= 1'h0;
            imem_rdata  <= 256'h0;
        end else begin
            imem_rvalid <= imem_rd;
            imem_rdata  <= imem_rd ? line_of(imem_addr) : ~imem_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // slow far side: ack only after pmp_lat cycles of a held request
    assign fire = pmp_req && !pmp_ack && (wait_q == pmp_lat);
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            wait_q    <= 4'h0;
            pmp_ack   <= 1'h0;
            pmp_rdata <= 256'h0;
        end else begin
            wait_q    <= (pmp_req && !pmp_ack) ? wait_q + 4'h1 : 4'h0;
            pmp_ack   <= fire;
            pmp_rdata <= fire ? line_of(pmp_addr) : ~pmp_rdata;
        end
    end
endmodule

// [verification/pfc_cache_bench.sv]
// Purpose: self-checking bench for the program fetch cache
// Assumes: small cache (1 KB) so line indexes are addr[9:5]
// Notes:   fetch outputs sampled at the falling edge, bus answers at the rising edge
`timescale 1ns/100ps
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin miscompares++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module pfc_cache_bench;
    localparam logic [31:0] LA = 32'h1000_0040;  // ram line
    localparam logic [31:0] LB = 32'h0000_0100;  // rom page 0
    localparam logic [31:0] LC = 32'h0004_0200;  // rom page 1
    localparam logic [31:0] LX = 32'h8000_0020;  // external
    logic                sys_clk    = 1'h0;
    logic                arst_n     = 1'h0;
    logic [2:0]          mode       = 3'h0;
    logic                fetch_req  = 1'h0;
    logic [31:0]         fetch_addr = 32'h0;
    logic [31:0]         salt       = 32'h0;
    logic                hsel       = 1'h0;
    logic [31:0]         haddr      = 32'h0;
    logic [1:0]          htrans     = 2'h0;
    logic                hwrite     = 1'h0;
    logic [31:0]         hwdata     = 32'h0;
    pfc_pkg::pfc_acc_s   d0 = '0, d1 = '0, pa = '0;
    logic                fetch_ready, fetch_valid, imem_rd, imem_rvalid, pmp_req, pmp_ack, hreadyout, hresp;
    logic [255:0]        fetch_data, imem_rdata, pmp_rdata;
    logic [31:0]         imem_addr, pmp_addr, hrdata, rd;
    logic [2:0]          acc_gnt;
    int                  miscompares = 0;
    int                  n_tests     = 0;

    always #10 sys_clk = ~sys_clk;

    pfc_cache #(.CACHE_BYTES(1024)) dut_u (.sys_clk(sys_clk), .arst_n(arst_n), .fetch_cache_mode_field(mode),
        .fetch_req(fetch_req), .fetch_addr(fetch_addr), .fetch_ready(fetch_ready), .fetch_valid(fetch_valid),
        .fetch_data(fetch_data), .imem_rd(imem_rd), .imem_addr(imem_addr), .imem_rvalid(imem_rvalid),
        .imem_rdata(imem_rdata), .pmp_req(pmp_req), .pmp_addr(pmp_addr), .pmp_ack(pmp_ack),
        .pmp_rdata(pmp_rdata), .dat0_acc(d0), .dat1_acc(d1), .per_acc(pa), .acc_gnt(acc_gnt), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp));

    pfc_mem_model mem_u (.sys_clk(sys_clk), .arst_n(arst_n), .salt(salt), .pmp_lat(4'h4), .imem_rd(imem_rd),
        .imem_addr(imem_addr), .imem_rvalid(imem_rvalid), .imem_rdata(imem_rdata), .pmp_req(pmp_req),
        .pmp_addr(pmp_addr), .pmp_ack(pmp_ack), .pmp_rdata(pmp_rdata));

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [255:0] line_of(input logic [31:0] a);
        for (int i = 0; i < 8; i++) begin
            line_of[i*32 +: 32] = {a[31:5], i[2:0], 2'h0} ^ ((a[31:28] == 4'h1) ? salt : 32'h0);
        end
    endfunction

    task automatic give_verdict();
        $display("comparisons=%0d miscompares=%0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // hreadyout read right after the edge is the value that edge sampled
    task automatic wait_rdy();
        int n;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (hreadyout !== 1'h1 && n < 50);
        if (hreadyout !== 1'h1) begin
            miscompares++;
            give_verdict();
        end
    endtask

    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        @(posedge sys_clk);
        hsel   <= 1'h1;
        haddr  <= a;
        hwrite <= wr;
        htrans <= pfc_pkg::HTRANS_NONSEQ;
        wait_rdy();
        hsel   <= 1'h0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
    endtask

    // exp_n is edges from the taking edge to the first cycle showing fetch_valid; 0 skips it
    task automatic fetch(input logic [31:0] a, input int exp_n);
        int n;
        n = 0;
        @(negedge sys_clk);
        while (fetch_ready !== 1'h1 && n < 60) begin
            @(negedge sys_clk);
            n++;
        end
        @(posedge sys_clk);
        fetch_req  <= 1'h1;
        fetch_addr <= a;
        @(posedge sys_clk);
        fetch_req  <= 1'h0;
        n = 0;
        do begin
            @(negedge sys_clk);
            n++;
        end while (fetch_valid !== 1'h1 && n < 60);
        if (fetch_valid !== 1'h1) begin
            miscompares++;
            give_verdict();
        end
        if (exp_n > 0) `CHK(n, exp_n)
        `CHK(fetch_data, line_of(a))
        @(posedge sys_clk);
    endtask

    task automatic arb(input logic [31:0] a0, a1, ap, input logic [2:0] v, input logic [2:0] exp);
        @(posedge sys_clk);
        d0 <= '{vld: v[0], addr: a0};
        d1 <= '{vld: v[1], addr: a1};
        pa <= '{vld: v[2], addr: ap};
        @(posedge sys_clk);
        @(negedge sys_clk);
        `CHK(acc_gnt, exp)
        @(posedge sys_clk);
        d0 <= '0;
        d1 <= '0;
        pa <= '0;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge sys_clk);
        arst_n <= 1'h1;
        ahb(1'h0, pfc_pkg::REG_INV_START, 32'h0);
        `CHK(rd, 32'h0)
        ahb(1'h0, pfc_pkg::REG_INV_CTRL, 32'h0);
        `CHK(rd, 32'h0)
        ahb(1'h0, 32'h2000_0008, 32'h0);
        `CHK(rd, 32'h0)
        `CHK(hresp, 1'h0)
        fetch(LA, 3);
        fetch(LA, 1);
        fetch(LX, 0);
        fetch(LX, 1);
        mode <= pfc_pkg::MODE_ENA;
        fetch(LB, 3);
        fetch(LB, 1);
        mode <= pfc_pkg::MODE_FRZ;
        fetch(LC, 3);
        fetch(LC, 3);
        fetch(LA, 1);
        mode <= pfc_pkg::MODE_BYP;
        fetch(LA, 3);
        mode <= pfc_pkg::MODE_ENA;
        fetch(LA, 1);
        // overlay: ram contents change, so the line must be invalidated and refetched
        salt <= 32'h5a5a_0f0f;
        ahb(1'h1, pfc_pkg::REG_INV_START, LA);
        ahb(1'h1, pfc_pkg::REG_INV_CTRL, 32'h8);
        for (int k = 0; k < 40; k++) begin
            ahb(1'h0, pfc_pkg::REG_INV_CTRL, 32'h0);
            if (rd === 32'h0) break;
        end
        `CHK(rd, 32'h0)
        ahb(1'h0, pfc_pkg::REG_INV_START, 32'h0);
        `CHK(rd, LA)
        fetch(LA, 3);
        fetch(LB, 1);
        // fill on a rom page while data traffic holds the ram page
        d0 <= '{vld: 1'h1, addr: 32'h1000_0004};
        fetch(32'h0000_0300, 3);
        // same-page data holds the fill back until it goes away
        d0 <= '{vld: 1'h1, addr: 32'h0000_0008};
        fork
            fetch(32'h0000_0400, 6);
            begin
                repeat (4) @(posedge sys_clk);
                d0 <= '0;
            end
        join
        arb(32'h1000_0004, 32'h0000_0000, 32'h0, 3'h3, 3'h3);
        arb(32'h1000_0004, 32'h1000_0024, 32'h0, 3'h3, 3'h1);
        arb(32'h1000_0004, 32'h1000_0008, 32'h0000_0000, 3'h7, 3'h7);
        give_verdict();
    end
endmodule
